// ==== hw/tu_adapter_defs.vh ====
// constants for the tu-3 / tu-2 pointer adapter
`ifndef TU_ADAPTER_DEFS_VH
`define TU_ADAPTER_DEFS_VH

// ----------------------------------------------------------------------
// group access frame geometry (three tug-3s, byte interleaved)
// ----------------------------------------------------------------------
`define GROUP_LAST      2'h2
`define GROUP_C         2'h2
`define COL_LAST        7'h55
`define ROW_LAST        4'h8
`define TU2_FIRST_COL   7'h02
`define TU2_BYTES_ROW   7'h0C
`define TU2_INDEX_MAX   3'h7
`define TU2_INDEX_MAX_C 3'h5

// ----------------------------------------------------------------------
// overhead positions
// ----------------------------------------------------------------------
`define ROW_H1          4'h0
`define ROW_H2          4'h1
`define ROW_H3          4'h2
`define COL_PTR         7'h00
`define COL_POS_OPP     7'h01
`define PHASE_V1        2'h0
`define PHASE_V2        2'h1
`define PHASE_V3        2'h2
`define TU2_POS_OPP     7'h01

// ----------------------------------------------------------------------
// pointer word fields
// ----------------------------------------------------------------------
`define NDF_NORMAL      4'h6
`define SS_TU3          2'h2
`define SS_TU2          2'h0
`define PTR_I_MASK      10'h2AA
`define PTR_D_MASK      10'h155
`define JUST_NONE       2'h0
`define JUST_POS        2'h1
`define JUST_NEG        2'h2

// ----------------------------------------------------------------------
// fill bytes and reset values
// ----------------------------------------------------------------------
`define BYTE_ALL_ONES   8'hFF
`define BYTE_STUFF      8'h00
`define PTR_RESET       10'h000

`endif

// ==== hw/elastic_store.v ====
// elastic store of flip-flops with fill level
`timescale 1ns/1ps
`default_nettype none

module elastic_store #(
   parameter WIDTH = 9,
   parameter DEPTH = 16,
   parameter AW    = 4
) (
   input  wire             clk,
   input  wire             rst,
   input  wire             wr_en,
   input  wire [WIDTH-1:0] wr_data,
   input  wire             rd_en,
   output wire [WIDTH-1:0] rd_data,
   output wire [AW:0]      fill
);

   localparam integer  LAST_I   = DEPTH - 1;
   localparam [AW:0]   FULL     = DEPTH[AW:0];
   localparam [AW-1:0] PTR_LAST = LAST_I[AW-1:0];

   reg [WIDTH-1:0] mem_q [0:DEPTH-1];
   reg [AW-1:0]    wr_ptr_q;
   reg [AW-1:0]    rd_ptr_q;
   reg [AW:0]      fill_q;
   wire            do_wr;
   wire            do_rd;

   function [AW-1:0] next_ptr;
      input [AW-1:0] p;
      begin
         next_ptr = (p == PTR_LAST) ? {AW{1'b0}} : p + 1'b1;
      end
   endfunction

   // a full store drops the write; an empty one returns zeros
   assign do_wr   = wr_en && (fill_q != FULL);
   assign do_rd   = rd_en && (fill_q != {(AW+1){1'b0}});
   assign rd_data = (fill_q != {(AW+1){1'b0}}) ? mem_q[rd_ptr_q]
                                               : {WIDTH{1'b0}};
   assign fill    = fill_q;

   always @(posedge clk)
   begin
      if (do_wr)
      begin
         mem_q[wr_ptr_q] <= wr_data;
      end
   end

   always @(posedge clk)
   begin
      if (rst)
      begin
         wr_ptr_q <= {AW{1'b0}};
         rd_ptr_q <= {AW{1'b0}};
         fill_q   <= {(AW+1){1'b0}};
      end
      else
      begin
         if (do_wr)
         begin
            wr_ptr_q <= next_ptr(wr_ptr_q);
         end
         if (do_rd)
         begin
            rd_ptr_q <= next_ptr(rd_ptr_q);
         end
         if (do_wr && !do_rd)
         begin
            fill_q <= fill_q + 1'b1;
         end
         else if (do_rd && !do_wr)
         begin
            fill_q <= fill_q - 1'b1;
         end
      end
   end

endmodule

`default_nettype wire

// ==== hw/tu3_tu2_pointer_adapter.v ====
// tu-3 / tu-2 adaptation source: elastic store, pointer, justification
//
// Overview of operation
// - accept vc-3 stream, 765x64 kbit/s, 4.6 ppm
// - vc-2 mode accepts 428x64/4 kbit/s stream
// - store written on tributary clock with markers
// - store read on path timing and justification
// - tu-3 positive skips h3+1, negative fills h3
// - tu-2 positive skips v3+1, negative fills v3
// - tu-3 pointer sent every frame, fixed place
// - tu-3 pointer in h1/h2, size 10
// - tu-2 pointer in v1/v2 per multiframe
// - tu-2 pointer size field is 00
// - v4 content is free, sent as stuff
// - tu-3 uses only group a or b
// - tu-2 slot from group and index
// - drive access point only while activated
// - tu-3 all ones follows fail, 250 us
// - tu-2 all ones follows fail, 1 ms
// - unconnected fail input counts as false
`timescale 1ns/1ps
`default_nettype none
`include "tu_adapter_defs.vh"

module tu3_tu2_pointer_adapter #(
   parameter DEPTH         = 16,
   parameter AW            = 4,
   parameter FILL_LO       = 5,
   parameter FILL_HI       = 11,
   parameter SSF_CONNECTED = 1
) (
   input  wire       ref_clk,
   input  wire       rst,
   input  wire       function_activate,
   input  wire       mode_tu2,
   input  wire [1:0] group_select,
   input  wire [2:0] tu_index,
   input  wire       server_signal_fail_in,
   input  wire       tributary_clock_in,
   input  wire [7:0] tributary_data_in,
   input  wire       tributary_frame_start_in,
   input  wire       path_timing_clock,
   input  wire       path_frame_start,
   input  wire       path_multiframe_start,
   output wire [7:0] group_access_data,
   output wire       group_access_drive,
   output wire       group_access_multiframe_start,
   output wire       alarm_insert_action
);

   localparam [AW:0] LO = FILL_LO[AW:0];
   localparam [AW:0] HI = FILL_HI[AW:0];

   // ----------------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------------
   reg  [13:0] pin_meta_q;
   reg  [13:0] pin_sync_q;
   reg         trib_clk_prev_q;
   reg         path_clk_prev_q;
   wire [13:0] pin_raw;
   wire        trib_edge;
   wire        path_edge;
   wire        frame_mark;
   wire        mframe_mark;

   assign pin_raw = {server_signal_fail_in, path_multiframe_start,
                     path_frame_start, path_timing_clock,
                     tributary_frame_start_in, tributary_data_in,
                     tributary_clock_in};

   always @(posedge ref_clk)
   begin
      if (rst)
      begin
         pin_meta_q      <= 14'h0000;
         pin_sync_q      <= 14'h0000;
         trib_clk_prev_q <= 1'b0;
         path_clk_prev_q <= 1'b0;
      end
      else
      begin
         pin_meta_q      <= pin_raw;
         pin_sync_q      <= pin_meta_q;
         trib_clk_prev_q <= pin_sync_q[0];
         path_clk_prev_q <= pin_sync_q[10];
      end
   end

   assign trib_edge   = pin_sync_q[0] && !trib_clk_prev_q;
   assign path_edge   = pin_sync_q[10] && !path_clk_prev_q;
   assign frame_mark  = pin_sync_q[11];
   assign mframe_mark = pin_sync_q[12];

   // an unconnected fail input is tied off by parameter
   assign alarm_insert_action = (SSF_CONNECTED != 0) && pin_sync_q[13];

   // ----------------------------------------------------------------------
   // elastic store
   // ----------------------------------------------------------------------
   wire       rd_en;
   wire [8:0] rd_word;
   wire [AW:0] fill;

   // one entry per tributary byte: frame marker above the data;
   // sampling works for vc-3 and vc-2 byte clocks alike
   elastic_store #(
      .WIDTH (9),
      .DEPTH (DEPTH),
      .AW    (AW)
   ) u_store (
      .clk     (ref_clk),
      .rst     (rst),
      .wr_en   (trib_edge),
      .wr_data ({pin_sync_q[9], pin_sync_q[8:1]}),
      .rd_en   (rd_en),
      .rd_data (rd_word),
      .fill    (fill)
   );

   // ----------------------------------------------------------------------
   // frame position counters
   // ----------------------------------------------------------------------
   reg  [1:0] grp_q;
   reg  [6:0] col_q;
   reg  [3:0] row_q;
   reg  [1:0] phase_q;
   reg  [1:0] n_grp;
   reg  [6:0] n_col;
   reg  [3:0] n_row;
   reg  [1:0] n_phase;

   function [3:0] div7;
      input [6:0] v;
      reg   [6:0] q;
      begin
         q    = v / 7'd7;
         div7 = q[3:0];
      end
   endfunction

   function [6:0] tu2_pos;
      input [3:0] row;
      input [6:0] col;
      reg   [6:0] q;
      begin
         q       = {3'b000, div7(col - `TU2_FIRST_COL)};
         tu2_pos = {3'b000, row} * `TU2_BYTES_ROW + q;
      end
   endfunction

   always @*
   begin
      n_grp   = grp_q;
      n_col   = col_q;
      n_row   = row_q;
      n_phase = phase_q;
      if (frame_mark)
      begin
         n_grp   = 2'h0;
         n_col   = 7'h00;
         n_row   = 4'h0;
         n_phase = mframe_mark ? 2'h0 : phase_q + 2'h1;
      end
      else if (grp_q != `GROUP_LAST)
      begin
         n_grp = grp_q + 2'h1;
      end
      else
      begin
         n_grp = 2'h0;
         if (col_q != `COL_LAST)
         begin
            n_col = col_q + 7'h01;
         end
         else
         begin
            n_col = 7'h00;
            n_row = (row_q == `ROW_LAST) ? 4'h0 : row_q + 4'h1;
         end
      end
   end

   always @(posedge ref_clk)
   begin
      if (rst)
      begin
         grp_q   <= 2'h0;
         col_q   <= 7'h00;
         row_q   <= 4'h0;
         phase_q <= 2'h0;
      end
      else if (path_edge)
      begin
         grp_q   <= n_grp;
         col_q   <= n_col;
         row_q   <= n_row;
         phase_q <= n_phase;
      end
   end

   // ----------------------------------------------------------------------
   // timeslot decode
   // ----------------------------------------------------------------------
   wire       cfg_ok;
   wire       owned;
   wire [6:0] k2;
   wire [6:0] col2;
   wire [6:0] sub7;
   wire       is_ptr1;
   wire       is_ptr2;
   wire       is_neg_opp;
   wire       is_pos_opp;
   wire       is_payload;

   assign col2 = n_col - `TU2_FIRST_COL;
   assign sub7 = col2 - {3'b000, div7(n_col - `TU2_FIRST_COL)} * 7'd7;
   assign k2   = tu2_pos(n_row, n_col);

   // tu-3 lives in group a or b only; tu-2 index limit depends on group
   assign cfg_ok = mode_tu2 ?
      ((group_select <= `GROUP_C) && (tu_index != 3'h0) &&
       (tu_index <= ((group_select == `GROUP_C) ? `TU2_INDEX_MAX_C
                                                 : `TU2_INDEX_MAX)))
      : (group_select < `GROUP_C);

   assign owned = cfg_ok && (n_grp == group_select) &&
      (!mode_tu2 || ((n_col >= `TU2_FIRST_COL) &&
                     (sub7 == {4'h0, tu_index - 3'h1})));

   // pointer bytes sit at fixed places in frame / multiframe
   assign is_ptr1 = mode_tu2 ? (k2 == 7'h00 && n_phase == `PHASE_V1)
      : (n_col == `COL_PTR && n_row == `ROW_H1);
   assign is_ptr2 = mode_tu2 ? (k2 == 7'h00 && n_phase == `PHASE_V2)
      : (n_col == `COL_PTR && n_row == `ROW_H2);
   assign is_neg_opp = mode_tu2 ? (k2 == 7'h00 && n_phase == `PHASE_V3)
      : (n_col == `COL_PTR && n_row == `ROW_H3);
   assign is_pos_opp = mode_tu2 ?
      (k2 == `TU2_POS_OPP && n_phase == `PHASE_V3)
      : (n_col == `COL_POS_OPP && n_row == `ROW_H3);
   assign is_payload = mode_tu2 ? (k2 != 7'h00) : (n_col != `COL_PTR);

   // ----------------------------------------------------------------------
   // justification and pointer generation
   // ----------------------------------------------------------------------
   reg  [1:0] just_q;
   reg  [9:0] ptr_q;
   reg  [9:0] offset_q;
   reg  [9:0] ptr_word_q;
   wire [1:0] just_now;
   wire [9:0] ptr_word;
   wire [9:0] cur_off;
   wire       slot;
   wire       skip_read;
   wire       extra_read;

   // low fill slows the reader, high fill speeds it up
   assign just_now = !is_ptr1 ? just_q
      : (fill < LO) ? `JUST_POS
      : (fill > HI) ? `JUST_NEG : `JUST_NONE;

   // flip the i bits to announce positive, d bits for negative
   assign ptr_word = ptr_q ^
      ((just_now == `JUST_POS) ? `PTR_I_MASK :
       (just_now == `JUST_NEG) ? `PTR_D_MASK : 10'h000);

   assign slot       = path_edge && owned;
   assign skip_read  = is_pos_opp && (just_q == `JUST_POS);
   assign extra_read = is_neg_opp && (just_q == `JUST_NEG);
   // reads go on under alarm so the store keeps draining
   assign rd_en      = slot && ((is_payload && !skip_read) ||
                                extra_read);
   assign cur_off    = is_pos_opp ? 10'h000 : offset_q + 10'h001;

   always @(posedge ref_clk)
   begin
      if (rst)
      begin
         just_q     <= `JUST_NONE;
         ptr_q      <= `PTR_RESET;
         offset_q   <= `PTR_RESET;
         ptr_word_q <= `PTR_RESET;
      end
      else if (slot)
      begin
         if (is_ptr1)
         begin
            just_q     <= just_now;
            ptr_word_q <= ptr_word;
         end
         else if (is_pos_opp)
         begin
            just_q <= `JUST_NONE;
         end
         if (is_payload)
         begin
            offset_q <= cur_off;
            // the frame start marker fixes the next pointer value
            if (!skip_read && rd_word[8])
            begin
               ptr_q <= cur_off;
            end
         end
      end
   end

   // ----------------------------------------------------------------------
   // output byte and access point drive
   // ----------------------------------------------------------------------
   reg  [7:0] byte_out;
   reg  [7:0] data_q;
   reg        drive_q;
   reg        mfs_q;
   wire [1:0] size_code;

   assign size_code = mode_tu2 ? `SS_TU2 : `SS_TU3;

   always @*
   begin
      byte_out = `BYTE_STUFF;
      if (alarm_insert_action)
      begin
         byte_out = `BYTE_ALL_ONES;
      end
      else if (is_ptr1)
      begin
         byte_out = {`NDF_NORMAL, size_code, ptr_word[9:8]};
      end
      else if (is_ptr2)
      begin
         byte_out = ptr_word_q[7:0];
      end
      else if (extra_read)
      begin
         byte_out = rd_word[7:0];
      end
      else if (is_payload && !skip_read)
      begin
         byte_out = rd_word[7:0];
      end
      // v4, h3 without negative action and fixed stuff stay zero
   end

   always @(posedge ref_clk)
   begin
      if (rst)
      begin
         data_q  <= `BYTE_STUFF;
         drive_q <= 1'b0;
         mfs_q   <= 1'b0;
      end
      else
      begin
         drive_q <= slot && function_activate;
         mfs_q   <= path_edge && frame_mark && mframe_mark &&
                    function_activate;
         if (slot && function_activate)
         begin
            data_q <= byte_out;
         end
      end
   end

   assign group_access_data             = data_q;
   assign group_access_drive            = drive_q;
   assign group_access_multiframe_start = mfs_q;

endmodule

`default_nettype wire

// ==== tb/adapter_props.sv ====
// port-level assertions for the tu-3 / tu-2 pointer adapter
`timescale 1ns/1ps
`default_nettype none
`include "tu_adapter_defs.vh"
module adapter_props (
   input wire logic       ref_clk,
   input wire logic       rst,
   input wire logic       function_activate,
   input wire logic       mode_tu2,
   input wire logic [1:0] group_select,
   input wire logic [2:0] tu_index,
   input wire logic       server_signal_fail_in,
   input wire logic       path_timing_clock,
   input wire logic [7:0] group_access_data,
   input wire logic       group_access_drive,
   input wire logic       group_access_multiframe_start,
   input wire logic       alarm_insert_action
);
   // ----------------------------------------------------------------
   // helpers and sequences
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   logic [3:0] since_edge_q;
   wire        bad_slot;
   // saturates so a stopped path clock never looks like a fresh edge
   always @(posedge ref_clk)
      since_edge_q <= $rose(path_timing_clock) ? 4'h0 :
                      (since_edge_q == 4'hF) ? 4'hF : since_edge_q + 4'h1;
   assign bad_slot = mode_tu2 ? (tu_index == 3'h0 ||
                     group_select > `GROUP_LAST || (group_select == `GROUP_C
                     && tu_index > `TU2_INDEX_MAX_C)) : (group_select > 2'h1);
   sequence fail_up;
      $rose(server_signal_fail_in);
   endsequence
   sequence fail_down;
      $fell(server_signal_fail_in);
   endsequence
   sequence alarm_settled;
      alarm_insert_action [*3];
   endsequence
   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   chk_alarm_raise: assert property (
      fail_up |-> ##[1:4] alarm_insert_action)
      else $error("alarm late after fail rise");
   chk_alarm_clear: assert property (
      fail_down |-> ##[1:4] !alarm_insert_action)
      else $error("alarm late after fail fall");
   chk_ones_sent: assert property (
      alarm_settled ##0 group_access_drive |->
      group_access_data == `BYTE_ALL_ONES)
      else $error("owned byte not all ones during alarm");
   chk_drive_pulse: assert property (
      group_access_drive |=> !group_access_drive)
      else $error("drive longer than one cycle");
   chk_mfs_pulse: assert property (
      group_access_multiframe_start |=> !group_access_multiframe_start)
      else $error("multiframe pulse longer than one cycle");
   chk_idle_quiet: assert property (
      !function_activate && !$past(function_activate) |->
      !group_access_drive && !group_access_multiframe_start)
      else $error("access point driven while inactive");
   chk_data_held: assert property (
      !group_access_drive |-> $stable(group_access_data))
      else $error("data changed outside an owned slot");
   chk_slot_legal: assert property (
      bad_slot |-> !group_access_drive)
      else $error("drive for an illegal timeslot");
   chk_drive_timing: assert property (
      group_access_drive |-> since_edge_q inside {[4'h1:4'h6]})
      else $error("drive not tied to a path clock edge");
endmodule
`default_nettype wire

// ==== tb/path_source_model.sv ====
// path timing and tributary source feeding the adapter
`timescale 1ns/1ps
`default_nettype none
module path_source_model (
   input  wire logic [15:0] trib_half,
   input  wire logic [9:0]  trib_len,
   output var logic         path_timing_clock,
   output var logic         path_frame_start,
   output var logic         path_multiframe_start,
   output var logic         tributary_clock_in,
   output var logic [7:0]   tributary_data_in,
   output var logic         tributary_frame_start_in,
   output var logic [1:0]   grp,
   output var logic [6:0]   col,
   output var logic [3:0]   row,
   output var logic [1:0]   frm
);
   int idx;
   int n;
   // ----------------------------------------------------------------
   // 64 ns byte clock; position moves mid-low so it is settled at drive
   // ----------------------------------------------------------------
   initial
   begin
      idx = 2317;
      frm = 2'h3;
      {path_timing_clock, path_frame_start, path_multiframe_start} = 3'h0;
      forever
      begin
         #16;
         idx = (idx + 1) % 2322;
         frm = frm + 2'((idx == 0) ? 1 : 0);
         grp = 2'(idx % 3);
         col = 7'(idx / 3 % 86);
         row = 4'(idx / 258);
         path_frame_start = (idx == 0);
         path_multiframe_start = (idx == 0) && (frm == 2'h0);
         #16 path_timing_clock = 1'b1;
         #32 path_timing_clock = 1'b0;
      end
   end
   // byte data never 00 or FF, so stuff and alarm bytes stand out
   initial
   begin
      n = 0;
      {tributary_clock_in, tributary_frame_start_in} = 2'b01;
      tributary_data_in = 8'h01;
      #1;
      forever
      begin
         #(trib_half) tributary_clock_in = 1'b1;
         #(trib_half) tributary_clock_in = 1'b0;
         n = (n + 1) % trib_len;
         tributary_data_in = 8'(1 + n % 253);
         tributary_frame_start_in = (n == 0);
      end
   end
endmodule
`default_nettype wire

// ==== tb/tu3_tu2_pointer_adapter_tb.sv ====
// self-checking bench for the tu-3 / tu-2 pointer adapter
`timescale 1ns/1ps
`default_nettype none
`include "tu_adapter_defs.vh"
module tu3_tu2_pointer_adapter_tb;
   localparam int FRAME = 2322 * 8;
   logic        ref_clk, rst, function_activate, mode_tu2;
   logic        server_signal_fail_in, alarm_insert_action;
   logic        path_timing_clock, path_frame_start, path_multiframe_start;
   logic        tributary_clock_in, tributary_frame_start_in;
   logic [7:0]  tributary_data_in, group_access_data;
   logic        group_access_drive, group_access_multiframe_start;
   logic [1:0]  group_select, grp, frm;
   logic [2:0]  tu_index;
   logic [6:0]  col;
   logic [3:0]  row;
   logic [15:0] trib_half;
   logic [9:0]  trib_len;
   int          n_errors, cmp_count;
   // a single source owns the timeslot
   tu3_tu2_pointer_adapter dut (
      .ref_clk(ref_clk), .rst(rst), .function_activate(function_activate),
      .mode_tu2(mode_tu2), .group_select(group_select), .tu_index(tu_index),
      .server_signal_fail_in(server_signal_fail_in),
      .tributary_clock_in(tributary_clock_in),
      .tributary_data_in(tributary_data_in),
      .tributary_frame_start_in(tributary_frame_start_in),
      .path_timing_clock(path_timing_clock),
      .path_frame_start(path_frame_start),
      .path_multiframe_start(path_multiframe_start),
      .group_access_data(group_access_data),
      .group_access_drive(group_access_drive),
      .group_access_multiframe_start(group_access_multiframe_start),
      .alarm_insert_action(alarm_insert_action));
   path_source_model model (
      .trib_half(trib_half), .trib_len(trib_len),
      .path_timing_clock(path_timing_clock),
      .path_frame_start(path_frame_start),
      .path_multiframe_start(path_multiframe_start),
      .tributary_clock_in(tributary_clock_in),
      .tributary_data_in(tributary_data_in),
      .tributary_frame_start_in(tributary_frame_start_in),
      .grp(grp), .col(col), .row(row), .frm(frm));
   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic setup(input logic m, input logic [1:0] g,
                        input logic [2:0] l, input logic [15:0] h);
      @(posedge ref_clk);
      {mode_tu2, group_select, tu_index, trib_half} <= {m, g, l, h};
      trib_len <= m ? 10'd428 : 10'd765;
      {function_activate, server_signal_fail_in, rst} <= 3'b101;
      repeat (4) @(posedge ref_clk);
      rst <= 1'b0;
   endtask
   task automatic wait_frame();
      do @(posedge ref_clk); while (!path_frame_start);
   endtask
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic tu2_slot();
      int n_own, n_mfs;
      {n_own, n_mfs} = 0;
      setup(1'b1, 2'h1, 3'h3, 16'd694);
      wait_frame();
      repeat (FRAME - 16)
      begin
         @(posedge ref_clk);
         #1;
         n_mfs += group_access_multiframe_start;
         if (group_access_drive)
         begin
            n_own++;
            check({grp, 7'((col + 5) % 7)}, {2'h1, 7'h02});
            if (col == 7'h04 && row == 4'h0)
               check(group_access_data[7:2], {`NDF_NORMAL, `SS_TU2});
         end
      end
      check(n_own, 108);
      check(n_mfs, 1);
   endtask
   task automatic bad_slots();
      int n;
      n = 0;
      setup(1'b0, `GROUP_C, 3'h0, 16'd694);
      repeat (400) @(posedge ref_clk) n += group_access_drive;
      setup(1'b1, `GROUP_C, 3'h6, 16'd694);
      wait_frame();
      repeat (2600) @(posedge ref_clk) n += group_access_drive;
      check(n, 0);
   endtask
   // fast then slow tributary: full store first, drained store next
   task automatic tu3_justify();
      int n_own;
      logic pos_seen, neg_seen;
      logic [1:0] f0;
      {n_own, pos_seen, neg_seen} = 0;
      setup(1'b0, 2'h0, 3'h0, 16'd90);
      wait_frame();
      f0 = frm;
      trib_half <= 16'd110;
      repeat (FRAME + 4400)
      begin
         @(posedge ref_clk);
         #1;
         if (group_access_drive)
         begin
            check(grp, 2'h0);
            n_own += (frm == f0);
            if (col == `COL_PTR && row == `ROW_H1)
               check(group_access_data[7:2], {`NDF_NORMAL, `SS_TU3});
            if (col == `COL_PTR && row > `ROW_H3)
               check(group_access_data, `BYTE_STUFF);
            if (frm == f0 && col == `COL_PTR && row == `ROW_H3)
               neg_seen = (group_access_data !== `BYTE_STUFF);
            if (frm != f0 && col == `COL_POS_OPP && row == `ROW_H3)
               pos_seen = (group_access_data === `BYTE_STUFF);
         end
      end
      check(n_own, 774);
      check({neg_seen, pos_seen}, 2'b11);
   endtask
   task automatic alarm_cycle();
      int n;
      n = 0;
      @(posedge ref_clk);
      server_signal_fail_in <= 1'b1;
      repeat (8) @(posedge ref_clk);
      check(alarm_insert_action, 1'b1);
      repeat (1000)
      begin
         @(posedge ref_clk);
         #1;
         if (group_access_drive)
            check(group_access_data, `BYTE_ALL_ONES);
      end
      @(posedge ref_clk);
      server_signal_fail_in <= 1'b0;
      repeat (1008) @(posedge ref_clk)
         n += (group_access_drive && group_access_data !== `BYTE_ALL_ONES);
      check(alarm_insert_action, 1'b0);
      check(n > 0, 1'b1);
   endtask
   task automatic idle_check();
      int n;
      logic [7:0] held;
      n = 0;
      @(posedge ref_clk);
      function_activate <= 1'b0;
      repeat (8) @(posedge ref_clk);
      held = group_access_data;
      repeat (1000) @(posedge ref_clk)
         n += group_access_drive | group_access_multiframe_start;
      check({n[7:0], group_access_data}, {8'h00, held});
      function_activate <= 1'b1;
      repeat (200) @(posedge ref_clk) n += group_access_drive;
      check(n > 0, 1'b1);
   endtask
   initial
   begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   initial
   begin
      {n_errors, cmp_count} = 0;
      {rst, function_activate, mode_tu2, server_signal_fail_in} <= 4'hE;
      {group_select, tu_index, trib_half, trib_len} <= {5'h0B, 16'd694, 10'd428};
      repeat (20) @(posedge ref_clk);
      tu2_slot();
      bad_slots();
      tu3_justify();
      alarm_cycle();
      idle_check();
      report_and_stop();
   end
   // about four and a half frames of traffic plus margin
   initial
   begin
      #720000;
      n_errors++;
      report_and_stop();
   end
endmodule
bind tu3_tu2_pointer_adapter adapter_props chk (
   .ref_clk(ref_clk), .rst(rst), .function_activate(function_activate),
   .mode_tu2(mode_tu2), .group_select(group_select), .tu_index(tu_index),
   .server_signal_fail_in(server_signal_fail_in),
   .path_timing_clock(path_timing_clock),
   .group_access_data(group_access_data),
   .group_access_drive(group_access_drive),
   .group_access_multiframe_start(group_access_multiframe_start),
   .alarm_insert_action(alarm_insert_action));
`default_nettype wire
